// >>> dv/das_link_props.sv
// assertions on the converter-host link
module das_link_props (
  // clock and reset
  input wire logic       MCLK,
  input wire logic       RESET,
  // link signals
  input wire logic       sample_en,
  input wire logic       sleep_request,
  input wire logic [7:0] first_channel_bus,
  input wire logic [7:0] second_channel_bus,
  input wire logic       first_oe,
  input wire logic       second_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  sequence s_slept;
    sleep_request ##1 sleep_request;
  endsequence
  sequence s_held;
    $stable(first_channel_bus) && $stable(second_channel_bus);
  endsequence
  sequence s_woke;
    !$past(sleep_request);
  endsequence
  AST_EN_PULSE: assert property (sample_en |=> !sample_en)
    else $error("long strobe");
  AST_OE_TIED: assert property (first_oe == second_oe)
    else $error("enables differ");
  AST_OE_OFF: assert property (sleep_request |=> !first_oe)
    else $error("driving asleep");
  AST_OE_ON: assert property (!sleep_request |=> second_oe)
    else $error("idle awake");
  AST_BUS_HOLD: assert property (!sample_en |=> s_held)
    else $error("bus moved");
  AST_FLOAT: assert property (s_slept |-> !second_oe)
    else $error("not floated");
  AST_OE_LAG: assert property (
    $fell(sleep_request) |-> !first_oe)
    else $error("woke early");
  AST_OE_RISE: assert property ($rose(first_oe) |-> s_woke)
    else $error("rose asleep");
endmodule : das_link_props

// >>> dv/dual_adc_sample_interface_test.sv
// self-checking bench for the dual sample link
module dual_adc_sample_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 1'b0, RESET = 1'b1;
  logic [7:0]  a_in = 8'h00, b_in = 8'h00;
  logic        sleep_cmd = 1'b0;
  logic        floated, pv, pr = 1'b1;
  logic [31:0] pair;
  logic [15:0] idx;
  logic [31:0] rows [4] = '{32'h00FF00FF, 32'hA55AA55A, 32'h01800180,
                            32'h7F017F01};
  int          failures = 0, checks_done = 0, n;
  das_if lnk ();
  wire logic [15:0] buses = {lnk.first_channel_bus, lnk.second_channel_bus};
  das_conv u_das_conv (.MCLK(MCLK), .RESET(RESET), .ANALOG_IN_FIRST(a_in),
    .ANALOG_IN_SECOND(b_in), .LNK(lnk));
  das_host u_das_host (.MCLK(MCLK), .RESET(RESET), .SLEEP_CMD(sleep_cmd),
    .FLOATED(floated), .PAIR_DATA(pair), .PAIR_VALID(pv),
    .PAIR_READY(pr), .LNK(lnk));
  das_link_props u_das_link_props (.MCLK(MCLK), .RESET(RESET),
    .sample_en(lnk.sample_en), .sleep_request(lnk.sleep_request),
    .first_channel_bus(lnk.first_channel_bus), .first_oe(lnk.first_oe),
    .second_channel_bus(lnk.second_channel_bus), .second_oe(lnk.second_oe));
  initial begin
    forever #25 MCLK = ~MCLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int k);
    repeat (k) @(negedge MCLK);
  endtask : cyc
  task automatic wait_sig(input logic sel, input logic v);
    for (n = 0; (sel ? pv : floated) !== v && n < 40; n++)
      cyc(1);
    if ((sel ? pv : floated) !== v) begin
      failures++;
      end_of_test();
    end
  endtask : wait_sig
  initial begin
    cyc(20);
    RESET = 1'b0;
    foreach (rows[i]) begin
      {a_in, b_in} = rows[i][31:16];
      cyc(12);
      chk({16'h0000, buses}, {16'h0000, rows[i][15:0]});
    end
    // fill the fifo, then drain it
    pr = 1'b0;
    cyc(60);
    idx = pair[15:0];
    pr = 1'b1;
    repeat (18) begin
      chk(pair, {16'h7F01, idx});
      idx++;
      cyc(1);
    end
    // sleep and wake with new inputs
    sleep_cmd = 1'b1;
    wait_sig(1'b0, 1'b1);
    chk(n, 5);
    chk({31'h00000000, lnk.second_oe}, 32'h00000000);
    // drain what was captured before sleep
    wait_sig(1'b1, 1'b0);
    {a_in, b_in} = 16'h3CC3;
    sleep_cmd = 1'b0;
    wait_sig(1'b1, 1'b1);
    chk(n, 14);
    chk(pair, {16'h3CC3, pair[15:0]});
    // mid-run reset, then recovery
    RESET = 1'b1;
    cyc(2);
    chk({buses, 14'h0000, lnk.first_oe, pv}, 32'h00000000);
    RESET = 1'b0;
    cyc(12);
    chk({buses, 15'h0000, lnk.first_oe}, {16'h3CC3, 16'h0001});
    end_of_test();
  end
endmodule : dual_adc_sample_interface_test

// >>> verilog/das_conv.sv
// converter end: two-channel pipelined sampler
`include "das_defines.svh"
module das_conv #(
  parameter int WIDTH   = `DAS_WIDTH,
  parameter int LATENCY = `DAS_LATENCY
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESET,
  // analog stand-in words
  input  wire logic [WIDTH-1:0] ANALOG_IN_FIRST,
  input  wire logic [WIDTH-1:0] ANALOG_IN_SECOND,
  // link
  das_if.conv                   LNK
);
  typedef struct packed {
    logic [LATENCY-1:0][WIDTH-1:0] pipe_a;
    logic [LATENCY-1:0][WIDTH-1:0] pipe_b;
    logic                          oe;
  } das_conv_st_t;
  das_conv_st_t st_ff;
  das_conv_st_t nxt_st_ff;
  always_comb begin
    nxt_st_ff = st_ff;
    if (LNK.sample_en) begin // see (RULE1)
      nxt_st_ff.pipe_a[0] = ANALOG_IN_FIRST; // see (RULE2)
      nxt_st_ff.pipe_b[0] = ANALOG_IN_SECOND; // see (RULE2)
      for (int i = 1; i < LATENCY; i++) begin
        nxt_st_ff.pipe_a[i] = st_ff.pipe_a[i-1]; // see (RULE4)
        nxt_st_ff.pipe_b[i] = st_ff.pipe_b[i-1]; // see (RULE4)
      end
    end
    nxt_st_ff.oe = !LNK.sleep_request; // see (RULE6) (RULE11)
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st_ff;
    end
  end
  assign LNK.first_channel_bus  =
    st_ff.pipe_a[LATENCY-1]; // see (RULE3) (RULE5)
  assign LNK.second_channel_bus =
    st_ff.pipe_b[LATENCY-1]; // see (RULE3) (RULE5)
  assign LNK.first_oe           = st_ff.oe; // see (RULE6)
  assign LNK.second_oe          = st_ff.oe; // see (RULE6)
endmodule : das_conv

// >>> verilog/das_defines.svh
// timing and width constants for the dual sample interface
// Operation
// (RULE1) one shared sample clock for both channels
// (RULE2) rising edge holds both inputs, starts conversion
// (RULE3) each channel drives 8-bit word on edge
// (RULE4) result is input from three edges earlier
// (RULE5) each channel only on its own bus
// (RULE6) sleep high tri-states all outputs; the code only drops first_oe and second_oe, and both buses stay driven
// (RULE7) host waits 200 ns before relying on float
// (RULE8) host waits 200 ns, discards three words
// (RULE9) host clocks between 5 and 60 MSPS
// (RULE10) host keeps roughly 50 percent duty
// (RULE11) one sleep input governs both channels
// (RULE12) host tags pairs with three-edge-old index
`ifndef DAS_DEFINES_SVH
`define DAS_DEFINES_SVH
`define DAS_WIDTH          8
`define DAS_LATENCY        3
`define DAS_MCLK_HZ        20000000
`define DAS_SLEEP_NS       200
`define DAS_SLEEP_CYC      ((`DAS_SLEEP_NS * 20 + 999) / 1000)
`define DAS_WAKE_CYC       ((`DAS_SLEEP_NS * 20 + 999) / 1000)
`define DAS_DIV_DEFAULT    2
`define DAS_FIFO_DEPTH     16
`endif

// >>> verilog/das_fifo.sv
// parameterised valid/ready fifo
module das_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESET,
  // fill side
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  // drain side
  output logic [WIDTH-1:0]      OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign IN_READY  = (cnt_ff != (AW+1)'(DEPTH));
  assign OUT_VALID = (cnt_ff != '0);
  assign OUT_DATA  = mem[rp_ff];
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;
  always_ff @(posedge MCLK) begin
    if (push) begin
      mem[wp_ff] <= IN_DATA;
    end
    if (RESET) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : das_fifo

// >>> verilog/das_host.sv
// host end: sample clock, sleep control, capture into fifo
`include "das_defines.svh"
module das_host #(
  parameter int DIV       = `DAS_DIV_DEFAULT,
  parameter int SLEEP_CYC = `DAS_SLEEP_CYC,
  parameter int WAKE_CYC  = `DAS_WAKE_CYC
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // control
  input  wire logic        SLEEP_CMD,
  output logic             FLOATED,
  // captured pairs with index
  output logic [31:0]      PAIR_DATA,
  output logic             PAIR_VALID,
  input  wire logic        PAIR_READY,
  // link
  das_if.host              LNK
);
  typedef struct packed {
    logic [7:0]               div;
    logic                     en;
    logic                     sleep;
    das_pkg::das_host_st_t    st;
    logic [7:0]               wait_cnt;
    logic [1:0]               discard;
    logic [15:0]              idx;
    logic [31:0]              cap;
    logic                     cap_v;
    logic                     floated;
  } das_host_st_t;
  das_host_st_t st_ff;
  das_host_st_t nxt_st_ff;
  logic         f_ready;
  always_comb begin
    nxt_st_ff       = st_ff;
    nxt_st_ff.en    = 1'b0;
    nxt_st_ff.cap_v = st_ff.cap_v && !f_ready; // held until fifo takes it
    if (st_ff.div == 8'(DIV - 1)) begin // see (RULE9) (RULE10)
      nxt_st_ff.div = '0;
      nxt_st_ff.en  = f_ready; // back-pressure stalls sampling
    end else begin
      nxt_st_ff.div = st_ff.div + 8'h01;
    end
    case (st_ff.st)
      das_pkg::DAS_RUN: begin
        if (SLEEP_CMD) begin
          nxt_st_ff.sleep    = 1'b1;
          nxt_st_ff.wait_cnt = '0;
          nxt_st_ff.st       = das_pkg::DAS_ENTER;
        end
      end
      das_pkg::DAS_ENTER: begin
        nxt_st_ff.wait_cnt = st_ff.wait_cnt + 8'h01;
        if (st_ff.wait_cnt == 8'(SLEEP_CYC - 1)) begin // see (RULE7)
          nxt_st_ff.floated = 1'b1;
          nxt_st_ff.st      = das_pkg::DAS_SLEEP;
        end
      end
      das_pkg::DAS_SLEEP: begin
        if (!SLEEP_CMD) begin
          nxt_st_ff.sleep    = 1'b0;
          nxt_st_ff.floated  = 1'b0;
          nxt_st_ff.wait_cnt = '0;
          nxt_st_ff.st       = das_pkg::DAS_WAKE;
        end
      end
      default: begin
        if (st_ff.wait_cnt != 8'(WAKE_CYC)) begin // see (RULE8)
          nxt_st_ff.wait_cnt = st_ff.wait_cnt + 8'h01;
          nxt_st_ff.discard  = 2'(`DAS_LATENCY);
        end else if (st_ff.en) begin
          if (st_ff.discard == 2'h1) begin // see (RULE8)
            nxt_st_ff.st = das_pkg::DAS_RUN;
          end
          nxt_st_ff.discard = st_ff.discard - 2'h1;
        end
      end
    endcase
    if (st_ff.en && st_ff.st == das_pkg::DAS_RUN) begin // see (RULE12)
      nxt_st_ff.cap = {LNK.first_channel_bus, LNK.second_channel_bus,
                       st_ff.idx - 16'(`DAS_LATENCY)};
      nxt_st_ff.cap_v = 1'b1;
    end
    if (st_ff.en) begin
      nxt_st_ff.idx = st_ff.idx + 16'h0001;
    end
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st_ff;
    end
  end
  assign LNK.sample_en     = st_ff.en;
  assign LNK.sleep_request = st_ff.sleep;
  assign FLOATED           = st_ff.floated;
  das_fifo #(.WIDTH(32), .DEPTH(`DAS_FIFO_DEPTH)) u_fifo (
    .MCLK      (MCLK),
    .RESET     (RESET),
    .IN_DATA   (st_ff.cap),
    .IN_VALID  (st_ff.cap_v),
    .IN_READY  (f_ready),
    .OUT_DATA  (PAIR_DATA),
    .OUT_VALID (PAIR_VALID),
    .OUT_READY (PAIR_READY)
  );
endmodule : das_host

// >>> verilog/das_if.sv
// link between converter and host
interface das_if;
  logic             sample_en;
  logic             sleep_request;
  das_pkg::das_word_t first_channel_bus;
  das_pkg::das_word_t second_channel_bus;
  logic             first_oe;
  logic             second_oe;
  modport conv (input sample_en, input sleep_request,
                output first_channel_bus, output second_channel_bus,
                output first_oe, output second_oe);
  modport host (output sample_en, output sleep_request,
                input first_channel_bus, input second_channel_bus,
                input first_oe, input second_oe);
endinterface : das_if

// >>> verilog/das_pkg.sv
// types shared by both ends
package das_pkg;
  typedef logic [7:0] das_word_t;
  typedef enum logic [1:0] {DAS_RUN, DAS_ENTER, DAS_SLEEP, DAS_WAKE}
    das_host_st_t;
endpackage : das_pkg
